// ### shared/dtc_consts.vh
// Register offsets, field positions, reset values and mode codes
`ifndef DTC_CONSTS_VH
`define DTC_CONSTS_VH
// ============================================================
// Register offsets (16-bit address space)
`define DTC_ADDR_PORT0_DIR    16'hff20
`define DTC_ADDR_TIMER_A_CTL  16'hff6d
`define DTC_ADDR_TIMER_B_CTL  16'hff6e
`define DTC_ADDR_CARRIER_CTL  16'hff6f
`define DTC_ADDR_CMP_A        16'hff70
`define DTC_ADDR_CMP_B        16'hff71
`define DTC_ADDR_CMP_HB       16'hff72
`define DTC_ADDR_CNT_A        16'hff73
`define DTC_ADDR_CNT_B        16'hff74
`define DTC_ADDR_STATUS       16'hff75
// ============================================================
// Reset values
`define DTC_RST_PORT0_DIR     8'hff
`define DTC_RST_CTL           8'h00
// ============================================================
// Timer B control fields
`define DTC_B_CE              7
`define DTC_B_CLK_HI          5
`define DTC_B_CLK_LO          3
`define DTC_B_MODE_HI         2
`define DTC_B_MODE_LO         1
`define DTC_B_OE              0
// Timer A control fields
`define DTC_A_CE              7
`define DTC_A_CLK_HI          4
`define DTC_A_CLK_LO          3
`define DTC_A_MODE            1
`define DTC_A_OE              0
// Carrier control fields
`define DTC_C_REMOTE          2
`define DTC_C_NEXT            1
`define DTC_C_CUR             0
// Port pins used by the timers
`define DTC_PIN_B_OUT         6
`define DTC_PIN_A_OUT         7
// ============================================================
// Mode codes {timer_a_mode_bit, timer_b_mode_hi, timer_b_mode_lo}
`define DTC_MODE_DISCRETE     3'h0
`define DTC_MODE_CASCADE      3'h5
`define DTC_MODE_CARRIER      3'h3
`define DTC_MODE_PWM          3'h2
// Timer B clock codes
`define DTC_CLKB_FX4          3'h0
`define DTC_CLKB_FX8          3'h1
`define DTC_CLKB_EXT          3'h2
`define DTC_CLKB_EXT2         3'h3
`define DTC_CLKB_EXT4         3'h4
`define DTC_CLKB_EXT8         3'h5
// Timer A clock codes
`define DTC_CLKA_FX16         2'h0
`define DTC_CLKA_FX64         2'h1
`define DTC_CLKA_BMATCH       2'h2
`define DTC_CLKA_BOUT         2'h3
// Prescaler width (fx/64 is the longest tap)
`define DTC_PRE_W             6
`endif

// ### hw/dtc_counter.v
// One 8-bit compare counter with clear on disable, match and overflow
`timescale 1ns/1ns
module dtc_counter #(
	parameter W = 8
) (
	// Clock and reset
	input  wire         clk,
	input  wire         rst,
	// Control
	input  wire         run,
	input  wire         tick,
	input  wire         clr_ext,
	input  wire [W-1:0] cmp,
	// State
	output reg  [W-1:0] count,
	output wire         at_match,
	output wire         at_top
);
	assign at_match = (count == cmp);
	assign at_top   = &count;

	always @(posedge clk) begin
		if (rst || !run)
			count <= {W{1'b0}};
		else if (clr_ext)
			count <= {W{1'b0}};
		else if (tick)
			count <= count + {{(W-1){1'b0}}, 1'b1};
	end
endmodule // dtc_counter

// ### hw/dtc_sync_edge.v
// Two-flop synchroniser with rising-edge pulse
`timescale 1ns/1ns
module dtc_sync_edge (
	// Clock and reset
	input  wire clk,
	input  wire rst,
	// Signal
	input  wire din,
	output reg  rise
);
	reg s1;
	reg s2;
	reg s3;

	always @(posedge clk) begin
		if (rst) begin
			s1   <= 1'b0;
			s2   <= 1'b0;
			s3   <= 1'b0;
			rise <= 1'b0;
		end else begin
			s1   <= din;
			s2   <= s1;
			s3   <= s2;
			rise <= s2 & ~s3;
		end
	end
endmodule // dtc_sync_edge

// ### hw/dtc_timer.v
// Dual 8-bit timer control: mode decode, clocks, counters, carrier output
`timescale 1ns/1ns
`include "dtc_consts.vh"
module dtc_timer (
	// Clock and reset
	input  wire        CLK_SYS,
	input  wire        RST,
	// Register port
	input  wire [15:0] ADDR,
	input  wire [7:0]  WDATA,
	input  wire        WR,
	input  wire        RD,
	output reg  [7:0]  RDATA,
	// Pins
	input  wire        EXT_COUNT_IN,
	input  wire [7:0]  PORT0_LATCH,
	output reg  [7:0]  PORT0_OUT,
	output reg  [7:0]  PORT0_OE_N,
	// Match requests
	output reg         TIMER_A_MATCH_IRQ,
	output reg         TIMER_B_MATCH_IRQ
);
	// ============================================================
	// Registers
	reg  [7:0] port0_direction;
	reg  [7:0] timer_a_mode_control;
	reg  [7:0] timer_b_mode_control;
	reg  [7:0] carrier_output_control;
	reg  [7:0] cmp_a;
	reg  [7:0] cmp_b;
	reg  [7:0] high_width_compare;
	reg  [`DTC_PRE_W-1:0] pre;
	reg  [2:0] ext_div;
	reg        b_out;
	reg        a_out;
	reg        carrier;
	reg        a_match_d;

	wire [7:0] cnt_a;
	wire [7:0] cnt_b;
	wire       a_match;
	wire       b_match;
	wire       a_top;
	wire       b_top;
	wire       ext_rise;

	// ============================================================
	// Field decode
	wire       timer_b_count_enable  = timer_b_mode_control[`DTC_B_CE];
	wire       timer_b_output_enable = timer_b_mode_control[`DTC_B_OE];
	wire [2:0] b_clk_sel = timer_b_mode_control[`DTC_B_CLK_HI:`DTC_B_CLK_LO];
	wire       timer_a_count_enable  = timer_a_mode_control[`DTC_A_CE];
	wire       timer_a_output_enable = timer_a_mode_control[`DTC_A_OE];
	wire [1:0] a_clk_sel = timer_a_mode_control[`DTC_A_CLK_HI:`DTC_A_CLK_LO];
	wire       remote_level_select = carrier_output_control[`DTC_C_REMOTE];
	wire       next_output_data    = carrier_output_control[`DTC_C_NEXT];
	wire       current_output_data = carrier_output_control[`DTC_C_CUR];

	function [3:0] dtc_mode_onehot;
		input [2:0] m;
		begin
			case (m)
			`DTC_MODE_DISCRETE: dtc_mode_onehot = 4'h1;
			`DTC_MODE_CASCADE:  dtc_mode_onehot = 4'h2;
			`DTC_MODE_CARRIER:  dtc_mode_onehot = 4'h4;
			`DTC_MODE_PWM:      dtc_mode_onehot = 4'h8;
			default:            dtc_mode_onehot = 4'h0;
			endcase
		end
	endfunction

	// Prohibited patterns decode to no mode; counters then idle
	wire [3:0] mode = dtc_mode_onehot({timer_a_mode_control[`DTC_A_MODE],
		timer_b_mode_control[`DTC_B_MODE_HI:`DTC_B_MODE_LO]});
	wire m_disc    = mode[0];
	wire m_cascade = mode[1];
	wire m_carrier = mode[2];
	wire m_pwm     = mode[3];

	// ============================================================
	// Count clocks
	dtc_sync_edge u_ext (
		.clk  (CLK_SYS),
		.rst  (RST),
		.din  (EXT_COUNT_IN),
		.rise (ext_rise)
	);

	always @(posedge CLK_SYS) begin
		if (RST) begin
			pre     <= {`DTC_PRE_W{1'b0}};
			ext_div <= 3'h0;
		end else begin
			pre <= pre + {{(`DTC_PRE_W-1){1'b0}}, 1'b1};
			if (!timer_b_count_enable)
				ext_div <= 3'h0;
			else if (ext_rise)
				ext_div <= ext_div + 3'h1;
		end
	end

	// Each tick is one cycle wide so a counter steps exactly once
	reg b_tick;
	always @* begin
		case (b_clk_sel)
		`DTC_CLKB_FX4:  b_tick = (pre[1:0] == 2'h3);
		`DTC_CLKB_FX8:  b_tick = (pre[2:0] == 3'h7);
		`DTC_CLKB_EXT:  b_tick = ext_rise;
		`DTC_CLKB_EXT2: b_tick = ext_rise & ext_div[0];
		`DTC_CLKB_EXT4: b_tick = ext_rise & (&ext_div[1:0]);
		`DTC_CLKB_EXT8: b_tick = ext_rise & (&ext_div);
		default:        b_tick = 1'b0;
		endcase
	end

	// Gated by run so a halted timer B cannot clock timer A
	wire b_event = b_run & b_tick & b_match;
	reg  b_out_d;
	always @(posedge CLK_SYS) begin
		if (RST)
			b_out_d <= 1'b0;
		else
			b_out_d <= b_out;
	end
	wire b_out_rise = b_out & ~b_out_d;

	reg a_tick_sel;
	always @* begin
		case (a_clk_sel)
		`DTC_CLKA_FX16:   a_tick_sel = (pre[3:0] == 4'hf);
		`DTC_CLKA_FX64:   a_tick_sel = (pre == {`DTC_PRE_W{1'b1}});
		`DTC_CLKA_BMATCH: a_tick_sel = b_event;
		`DTC_CLKA_BOUT:   a_tick_sel = b_out_rise;
		default:          a_tick_sel = 1'b0;
		endcase
	end

	// Cascade: A counts B wraps, both governed by B enable
	wire a_run = m_cascade ? timer_b_count_enable
		: (timer_a_count_enable & (m_disc | m_carrier | m_pwm));
	wire b_run = timer_b_count_enable & (|mode);
	wire casc_match = a_match & b_match;
	wire casc_top   = a_top & b_top;
	wire b_wrap_c   = b_tick & (b_top | casc_match);
	wire a_tick = m_cascade ? b_wrap_c : a_tick_sel;

	// ============================================================
	// Counters and clear sources
	wire a_clr = a_tick & (m_cascade ? (casc_match | casc_top)
		: (a_match | a_top));
	wire b_clr = b_tick & (m_cascade ? (casc_match | casc_top)
		: (b_match | b_top
		| ((m_carrier | m_pwm) & (cnt_b == high_width_compare))));

	dtc_counter #(.W(8)) u_cnt_a (
		.clk      (CLK_SYS),
		.rst      (RST),
		.run      (a_run),
		.tick     (a_tick),
		.clr_ext  (a_clr),
		.cmp      (cmp_a),
		.count    (cnt_a),
		.at_match (a_match),
		.at_top   (a_top)
	);

	dtc_counter #(.W(8)) u_cnt_b (
		.clk      (CLK_SYS),
		.rst      (RST),
		.run      (b_run),
		.tick     (b_tick),
		.clr_ext  (b_clr),
		.cmp      (cmp_b),
		.count    (cnt_b),
		.at_match (b_match),
		.at_top   (b_top)
	);

	wire a_hit = a_run & a_tick & (m_cascade ? 1'b0 : a_match);
	wire b_hit = b_run & b_tick & (m_cascade ? casc_match : b_match);
	wire hw_hit = b_run & b_tick & (cnt_b == high_width_compare);

	// ============================================================
	// Timer outputs and carrier
	always @(posedge CLK_SYS) begin
		if (RST) begin
			b_out     <= 1'b0;
			a_out     <= 1'b0;
			carrier   <= 1'b0;
			a_match_d <= 1'b0;
		end else begin
			a_match_d <= a_hit;
			if (!b_run)
				b_out <= 1'b0;
			else if (b_hit)
				b_out <= ~b_out;
			if (!a_run)
				a_out <= 1'b0;
			else if (a_hit)
				a_out <= ~a_out;
			// Carrier: high on B match, low on high-width match
			if (!b_run)
				carrier <= 1'b0;
			else if (hw_hit)
				carrier <= 1'b0;
			else if (b_hit)
				carrier <= 1'b1;
		end
	end

	wire a_match_rise = a_hit & ~a_match_d;
	wire carrier_pin = current_output_data
		& (remote_level_select | carrier);
	wire b_pin = m_carrier ? carrier_pin : (m_pwm ? carrier : b_out);

	// ============================================================
	// Register writes
	wire [7:0] cur_mask = {7'h00, ~timer_b_output_enable};
	always @(posedge CLK_SYS) begin
		if (RST) begin
			port0_direction        <= `DTC_RST_PORT0_DIR;
			timer_a_mode_control   <= `DTC_RST_CTL;
			timer_b_mode_control   <= `DTC_RST_CTL;
			carrier_output_control <= `DTC_RST_CTL;
			cmp_a                  <= 8'h00;
			cmp_b                  <= 8'h00;
			high_width_compare     <= 8'h00;
		end else begin
			if (WR) begin
				case (ADDR)
				`DTC_ADDR_PORT0_DIR:   port0_direction <= WDATA;
				`DTC_ADDR_TIMER_A_CTL: timer_a_mode_control <= WDATA & 8'h9b;
				`DTC_ADDR_TIMER_B_CTL: timer_b_mode_control <= WDATA & 8'hbf;
				`DTC_ADDR_CMP_A:       cmp_a <= WDATA;
				`DTC_ADDR_CMP_B:       cmp_b <= WDATA;
				`DTC_ADDR_CMP_HB:      high_width_compare <= WDATA;
				default:               ;
				endcase
			end
			// Transfer beats a same-cycle write to the current bit
			if (m_carrier && a_match_rise)
				carrier_output_control[`DTC_C_CUR] <= next_output_data;
			else if (WR && ADDR == `DTC_ADDR_CARRIER_CTL)
				carrier_output_control[`DTC_C_CUR] <=
					(WDATA[0] & cur_mask[0])
					| (current_output_data & ~cur_mask[0]);
			if (WR && ADDR == `DTC_ADDR_CARRIER_CTL)
				carrier_output_control[7:1] <= {5'h00,
					WDATA[`DTC_C_REMOTE], WDATA[`DTC_C_NEXT]};
		end
	end

	// ============================================================
	// Read port, pins and requests
	always @(posedge CLK_SYS) begin
		if (RST) begin
			RDATA             <= 8'h00;
			PORT0_OUT         <= 8'h00;
			PORT0_OE_N        <= 8'hff;
			TIMER_A_MATCH_IRQ <= 1'b0;
			TIMER_B_MATCH_IRQ <= 1'b0;
		end else begin
			RDATA <= 8'h00;
			if (RD) begin
				case (ADDR)
				`DTC_ADDR_PORT0_DIR:   RDATA <= port0_direction;
				`DTC_ADDR_TIMER_A_CTL: RDATA <= timer_a_mode_control;
				`DTC_ADDR_TIMER_B_CTL: RDATA <= timer_b_mode_control;
				`DTC_ADDR_CARRIER_CTL: RDATA <= carrier_output_control;
				`DTC_ADDR_CMP_A:       RDATA <= cmp_a;
				`DTC_ADDR_CMP_B:       RDATA <= cmp_b;
				`DTC_ADDR_CMP_HB:      RDATA <= high_width_compare;
				`DTC_ADDR_CNT_A:       RDATA <= cnt_a;
				`DTC_ADDR_CNT_B:       RDATA <= cnt_b;
				`DTC_ADDR_STATUS:      RDATA <= {4'h0, mode};
				default:               RDATA <= 8'h00;
				endcase
			end
			PORT0_OE_N <= port0_direction;
			PORT0_OUT  <= PORT0_LATCH;
			// Timer drives the pin only when enabled; the port
			// latch must be 0 for the OR to pass timer data
			PORT0_OUT[`DTC_PIN_B_OUT] <= PORT0_LATCH[`DTC_PIN_B_OUT]
				| (timer_b_output_enable & b_pin);
			PORT0_OUT[`DTC_PIN_A_OUT] <= PORT0_LATCH[`DTC_PIN_A_OUT]
				| (timer_a_output_enable & a_out);
			TIMER_A_MATCH_IRQ <= a_hit;
			TIMER_B_MATCH_IRQ <= b_hit;
		end
	end
endmodule // dtc_timer

// ### testbench/dtc_checker.sv
// Port-level assertions for the dual timer block
`timescale 1ns/1ns
`include "dtc_consts.vh"
module dtc_checker (
	// Watched ports
	input wire        CLK_SYS,
	input wire        RST,
	input wire [15:0] ADDR,
	input wire [7:0]  WDATA,
	input wire        WR,
	input wire        RD,
	input wire [7:0]  RDATA,
	input wire [7:0]  PORT0_LATCH,
	input wire [7:0]  PORT0_OUT,
	input wire [7:0]  PORT0_OE_N,
	input wire        TIMER_A_MATCH_IRQ,
	input wire        TIMER_B_MATCH_IRQ
);
	reg [7:0]  a;
	reg [7:0]  b;
	reg [7:0]  c;
	wire [2:0] md = {a[1], b[2:1]};
	wire       car = md == `DTC_MODE_CARRIER;
	wire       q = !TIMER_A_MATCH_IRQ;
	wire       wdir = WR && ADDR == `DTC_ADDR_PORT0_DIR;
	wire       bad = md == 3'h1 || md == 3'h4 || md > 3'h5;
	// Shadow registers; the data bit lags a match by one cycle
	always @(posedge CLK_SYS)
		if (RST) begin
			a <= 8'h00;
			b <= 8'h00;
			c <= 8'h00;
		end else if (WR && ADDR == `DTC_ADDR_TIMER_A_CTL)
			a <= WDATA & 8'h9b;
		else if (WR && ADDR == `DTC_ADDR_TIMER_B_CTL)
			b <= WDATA & 8'hbf;
		else if (WR && ADDR == `DTC_ADDR_CARRIER_CTL)
			c <= {5'h00, WDATA[2:1], b[0] ? c[0] : WDATA[0]};
		else if (TIMER_A_MATCH_IRQ && car)
			c[0] <= c[1];
	default clocking dc @(posedge CLK_SYS);
	endclocking
	default disable iff (RST);
	// ============================================================
	// Assertions
	a_dir_drives: assert property (
		wdir ##1 !wdir |=> PORT0_OE_N == $past(WDATA, 2))
		else $error("direction not on output enables");
	a_data_guard: assert property (
		RD && ADDR == `DTC_ADDR_CARRIER_CTL && q |=> RDATA == $past(c))
		else $error("carrier control readback wrong");
	a_b_halted: assert property (
		(!b[7]) [*2] |-> !TIMER_B_MATCH_IRQ)
		else $error("timer B request while halted");
	a_bad_mode: assert property (
		bad [*2] |-> !TIMER_A_MATCH_IRQ && !TIMER_B_MATCH_IRQ)
		else $error("request in prohibited mode");
	a_cascade_quiet: assert property (
		(md == `DTC_MODE_CASCADE) [*2] |-> q)
		else $error("timer A request in cascade");
	a_level_high: assert property (
		(car && b[0] && c[2] && c[0] && q) [*3] |-> PORT0_OUT[6])
		else $error("timer B pin not held high");
	a_data_low: assert property (
		(car && !c[0] && q) [*3] |-> PORT0_OUT[6] == $past(PORT0_LATCH[6]))
		else $error("timer B pin not low");
	a_port_mode: assert property (
		(!b[0] && !a[0]) [*3] |-> PORT0_OUT[7:6] == $past(PORT0_LATCH[7:6]))
		else $error("disabled output not left to port");
	cover property (md == `DTC_MODE_CASCADE && TIMER_B_MATCH_IRQ);
	cover property (car && TIMER_A_MATCH_IRQ);
	cover property (wdir);
endmodule // dtc_checker

// ### testbench/dtc_pin_model.sv
// Pulse source on the external count pin
`timescale 1ns/1ns
module dtc_pin_model (
	// Clock and command
	input  wire       clk,
	input  wire       start,
	input  wire [7:0] n_pulse,
	// Pin and status
	output reg        busy,
	output reg        ext_in
);
	reg [7:0] left;
	reg [2:0] ph;
	initial begin
		busy = 1'b0;
		ext_in = 1'b0;
		left = 8'h00;
		ph = 3'h0;
	end
	// Eight cycles a pulse, so no edge is lost in synchronising
	always @(posedge clk) begin
		ph <= start ? 3'h0 : ph + 3'h1;
		if (start) begin
			left <= n_pulse;
			busy <= 1'b1;
		end else if (busy) begin
			ext_in <= !ph[2];
			if (ph == 3'h7) begin
				left <= left - 8'h01;
				busy <= left != 8'h01;
			end
		end
	end
endmodule // dtc_pin_model

// ### testbench/dtc_timer_bench.sv
// Register-level bench for the dual timer block
`timescale 1ns/1ns
`include "dtc_consts.vh"
module dtc_timer_bench;
	localparam [15:0] r_a = `DTC_ADDR_TIMER_A_CTL;
	localparam [15:0] r_b = `DTC_ADDR_TIMER_B_CTL;
	localparam [15:0] r_c = `DTC_ADDR_CARRIER_CTL;
	reg        clk_sys;
	reg        rst;
	reg [15:0] addr;
	reg [7:0]  wdata;
	reg        wr;
	reg        rd;
	reg [7:0]  latch;
	reg        start;
	reg [7:0]  rv;
	wire [7:0] rdata, p_out, p_oe_n;
	wire       irq_a, irq_b, ext_in, busy;
	integer    error_cnt, n_checks, na, nb, i, k, p;
	dtc_timer DUT (.CLK_SYS(clk_sys), .RST(rst), .ADDR(addr), .WDATA(wdata),
		.WR(wr), .RD(rd), .RDATA(rdata), .EXT_COUNT_IN(ext_in),
		.PORT0_LATCH(latch), .PORT0_OUT(p_out), .PORT0_OE_N(p_oe_n),
		.TIMER_A_MATCH_IRQ(irq_a), .TIMER_B_MATCH_IRQ(irq_b));
	dtc_pin_model u_pins (.clk(clk_sys), .start(start), .n_pulse(8'h08),
		.busy(busy), .ext_in(ext_in));
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		if (irq_a)
			na = na + 1;
		if (irq_b)
			nb = nb + 1;
	end
	// ============================================================
	// Tasks
	task check(input [15:0] seen, input [15:0] exp);
		begin
			n_checks = n_checks + 1;
			if (seen !== exp) begin
				error_cnt = error_cnt + 1;
				$display("wrong value at %0t: %h, expected %h",
					$time, seen, exp);
			end
		end
	endtask
	task finish_test;
		begin
			if (error_cnt == 0 && n_checks > 0)
				$display("Run complete: PASS");
			else
				$display("Run complete: FAIL");
			$finish;
		end
	endtask
	task wr_reg(input [15:0] a, input [7:0] d);
		begin
			@(posedge clk_sys);
			wr <= 1'b1;
			addr <= a;
			wdata <= d;
			@(posedge clk_sys);
			wr <= 1'b0;
		end
	endtask
	task rd_reg(input [15:0] a);
		begin
			@(posedge clk_sys);
			rd <= 1'b1;
			addr <= a;
			@(posedge clk_sys);
			rd <= 1'b0;
			#1 rv = rdata;
		end
	endtask
	// Cycles between two requests; the first one may come early
	task gap(input sel);
		integer c;
		integer t;
		begin
			c = 0;
			t = 0;
			for (k = 0; k < 10000 && c < 2; k = k + 1) begin
				@(posedge clk_sys);
				#1;
				if (sel ? irq_a : irq_b) begin
					c = c + 1;
					p = k - t;
					t = k;
				end
			end
			if (c < 2) begin
				check(16'h0000, 16'h0001);
				finish_test;
			end
		end
	endtask
	// ============================================================
	// Scenarios
	initial begin
		rst = 1'b1;
		addr = 16'h0000;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
		latch = 8'h00;
		start = 1'b0;
		error_cnt = 0;
		n_checks = 0;
		repeat (4) @(posedge clk_sys);
		rst <= 1'b0;
		rd_reg(`DTC_ADDR_PORT0_DIR);
		check(rv, 8'hff);
		check(p_oe_n, 8'hff);
		rd_reg(16'hff21);
		check(rv, 8'h00);
		latch <= 8'hc0;
		wr_reg(`DTC_ADDR_PORT0_DIR, 8'h3f);
		wr_reg(r_b, 8'h40);
		rd_reg(r_b);
		check(rv, 8'h00);
		check(p_oe_n, 8'h3f);
		check(p_out, 8'hc0);
		latch <= 8'h00;
		wr_reg(`DTC_ADDR_CMP_B, 8'h02);
		for (i = 0; i < 2; i = i + 1) begin
			wr_reg(r_b, {4'h8, i[0], 3'h0});
			gap(1'b0);
			check(p[15:0], 16'h000c << i);
			wr_reg(r_b, 8'h00);
			rd_reg(`DTC_ADDR_CNT_B);
			check(rv, 8'h00);
		end
		// Shortest interval on both taps, then the longest on fx/16
		for (i = 0; i < 3; i = i + 1) begin
			wr_reg(`DTC_ADDR_CMP_A, (i == 2) ? 8'hff : 8'h00);
			wr_reg(r_a, (i == 1) ? 8'h88 : 8'h80);
			gap(1'b1);
			check(p[15:0], (i == 2) ? 16'h1000 : 16'h0010 << (2 * i));
			wr_reg(r_a, 8'h00);
		end
		// Timer A clocked by timer B match, then by timer B output
		wr_reg(`DTC_ADDR_CMP_B, 8'h01);
		wr_reg(`DTC_ADDR_CMP_A, 8'h01);
		wr_reg(r_b, 8'h80);
		for (i = 2; i < 4; i = i + 1) begin
			wr_reg(r_a, {3'h4, i[1:0], 3'h0});
			gap(1'b1);
			check(p[15:0], 16'h0004 << i);
			wr_reg(r_a, 8'h00);
		end
		wr_reg(r_b, 8'h00);
		// Eight pin edges through each divider tap
		wr_reg(`DTC_ADDR_CMP_B, 8'h00);
		for (i = 2; i < 6; i = i + 1) begin
			wr_reg(r_b, {2'h2, i[2:0], 3'h0});
			nb = 0;
			start <= 1'b1;
			@(posedge clk_sys);
			start <= 1'b0;
			for (k = 0; k < 200 && (busy !== 1'b0 || k < 2); k = k + 1)
				@(posedge clk_sys);
			repeat (8) @(posedge clk_sys);
			#1;
			check(busy, 1'b0);
			if (busy !== 1'b0)
				finish_test;
			check(nb[15:0], 16'h0008 >> (i - 2));
			wr_reg(r_b, 8'h00);
		end
		for (i = 0; i < 3; i = i + 1) begin
			wr_reg(r_b, (i == 2) ? 8'h82 : {4'hb, i[0], 3'h0});
			nb = 0;
			repeat (100) @(posedge clk_sys);
			check(nb[15:0], 16'h0000);
			rd_reg(`DTC_ADDR_STATUS);
			check(rv, (i == 2) ? 8'h00 : 8'h01);
		end
		wr_reg(r_b, 8'h00);
		wr_reg(`DTC_ADDR_CMP_A, 8'h00);
		wr_reg(`DTC_ADDR_CMP_B, 8'h03);
		wr_reg(r_a, 8'h02);
		wr_reg(r_b, 8'h82);
		gap(1'b0);
		na = 0;
		check(p[15:0], 16'h0010);
		repeat (100) @(posedge clk_sys);
		check(na[15:0], 16'h0000);
		rd_reg(`DTC_ADDR_STATUS);
		check(rv, 8'h02);
		wr_reg(r_b, 8'h00);
		wr_reg(r_a, 8'h00);
		wr_reg(r_b, 8'h04);
		rd_reg(`DTC_ADDR_STATUS);
		check(rv, 8'h08);
		wr_reg(r_c, 8'h05);
		wr_reg(r_b, 8'h07);
		wr_reg(r_c, 8'h04);
		rd_reg(r_c);
		check(rv, 8'h05);
		check(p_out[6], 1'b1);
		wr_reg(r_a, 8'h80);
		repeat (40) @(posedge clk_sys);
		rd_reg(r_c);
		check(rv, 8'h04);
		check(p_out[6], 1'b0);
		finish_test;
	end
endmodule // dtc_timer_bench
bind dtc_timer dtc_checker u_chk (.CLK_SYS(CLK_SYS), .RST(RST), .ADDR(ADDR),
	.WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
	.PORT0_LATCH(PORT0_LATCH), .PORT0_OUT(PORT0_OUT),
	.PORT0_OE_N(PORT0_OE_N), .TIMER_A_MATCH_IRQ(TIMER_A_MATCH_IRQ),
	.TIMER_B_MATCH_IRQ(TIMER_B_MATCH_IRQ));
